/* pkg/lmc_defines.svh */
`ifndef LMC_DEFINES_SVH
`define LMC_DEFINES_SVH
// standard configuration field positions
`define LMC_BL_LSB        0
`define LMC_BT_BIT        3
`define LMC_CL_LSB        4
`define LMC_OPMODE_LSB    7
// extended configuration field positions
`define LMC_PARTIAL_REFRESH_SELECT_LSB      0
`define LMC_TEMP_COMP_REFRESH_BITS_LSB      3
`define LMC_DS_LSB        5
// reset values
`define LMC_STD_RESET     12'h032
`define LMC_EXT_RESET     12'h000
// config load wait in ns and cycles at 5 ns period
`define LMC_MRD_NS        10
`define LMC_CLK_NS        5
`define LMC_MRD_CYC       ((`LMC_MRD_NS + `LMC_CLK_NS - 1) / `LMC_CLK_NS)
// controller register offsets on the AHB-Lite bus
`define LMC_OFS_CTRL      32'h0000_0000
`define LMC_OFS_ADDR      32'h0000_0004
`define LMC_OFS_STATUS    32'h0000_0008
`endif

/* pkg/lmc_pkg.sv */
package lmc_pkg;
  typedef enum logic [2:0] {
    LMC_CMD_NOP  = 3'h0,
    LMC_CMD_LOAD = 3'h1,
    LMC_CMD_READ = 3'h2,
    LMC_CMD_WRITE= 3'h3,
    LMC_CMD_DPD  = 3'h4
  } lmc_cmd_t;
  typedef enum logic [1:0] {
    LMC_DS_FULL    = 2'h0,
    LMC_DS_HALF    = 2'h1,
    LMC_DS_QUARTER = 2'h2
  } lmc_drive_t;
  typedef enum logic [2:0] {
    LMC_PR_ALL   = 3'h0,
    LMC_PR_HALF  = 3'h1,
    LMC_PR_QUART = 3'h2,
    LMC_PR_EIGHT = 3'h5,
    LMC_PR_SIXT  = 3'h6
  } lmc_partial_refresh_select_t;
endpackage

/* pkg/lmc_if.sv */
`timescale 1ns/1ps
interface lmc_if;
  import lmc_pkg::*;
  logic [2:0]  cmd;
  logic [1:0]  bank_sel;
  logic [11:0] addr;
  logic [3:0]  col_offset;
  logic        data_valid;
  logic        data_last;
  modport device (input cmd, bank_sel, addr,
                  output col_offset, data_valid, data_last);
  modport ctrl   (output cmd, bank_sel, addr,
                  input col_offset, data_valid, data_last);
endinterface

/* rtl/lmc_device.sv */
// Added by the designer: the register addresses and the AHB-Lite register port.
`timescale 1ns/1ps
`include "lmc_defines.svh"
// Notes on behaviour
// R1: burst lengths 2, 4, 8, 16, both types
// R2: burst wraps within aligned block
// R3: upper column bits select the block
// R4: low column bits give start offset
// R5: one length for reads and writes
// R6: order from length, type, start only
// R7: type bit picks sequential or interleaved
// R8: read latency two or three cycles
// R9: first data one/two clocks after edge
// R10: normal mode needs zero upper bits
// R11: controller never loads reserved upper bits
// R12: extended config loads with bank 2'b10
// R13: extended config cleared by deep sleep
// R14: temperature bits written are ignored
// R15: refresh all, banks 0-1, bank 0
// R16: eighth and sixteenth of bank 0
// R17: access unaffected by refresh select
// R18: drive full, three-quarter, half strength; lmc_drive_t names codes 1 and 2 half and quarter
// R19: standard config loads with bank 2'b00
// R20: load only idle, then wait
// R21: offset start+k or start xor k
module lmc_device
  import lmc_pkg::*;
(
  // clock and reset
  input  wire logic        mclk_i,
  input  wire logic        rst_b_i,
  // link
  lmc_if.device            bus,
  // decoded settings
  output logic [4:0]       burst_len_o,
  output logic             interleave_o,
  output logic [1:0]       read_latency_setting_o,
  output logic             reserved_mode_o,
  output logic [3:0]       refresh_bank_mask_o,
  output logic [1:0]       refresh_row_zero_bits_o,
  output logic [5:0]       drive_ohms_o
);
  logic [11:0] std_cfg;
  logic [11:0] ext_cfg;
  logic [3:0]  beat;
  logic [3:0]  start;
  logic [3:0]  len_mask;
  logic        active;
  logic [2:0]  lat_cnt;
  logic        lat_run;
  logic [3:0]  next_offset;
  logic [2:0]  kept_banks;

  // configuration loads
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      std_cfg <= `LMC_STD_RESET;
    end else if (bus.cmd == LMC_CMD_DPD) begin
      std_cfg <= `LMC_STD_RESET; // R19
    end else if (bus.cmd == LMC_CMD_LOAD && bus.bank_sel == 2'h0) begin
      std_cfg <= bus.addr; // R19 R10
    end
  end

  // deep sleep returns both registers to their reset values; they must be reloaded
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ext_cfg <= `LMC_EXT_RESET;
    end else if (bus.cmd == LMC_CMD_DPD) begin
      ext_cfg <= `LMC_EXT_RESET; // R13
    end else if (bus.cmd == LMC_CMD_LOAD && bus.bank_sel == 2'h2) begin
      ext_cfg <= bus.addr; // R12
    end
  end

  // burst length mask, one setting for both directions
  always_comb begin
    unique case (std_cfg[`LMC_BL_LSB +: 3]) // R1 R5
      3'h1:    len_mask = 4'h1;
      3'h2:    len_mask = 4'h3;
      3'h3:    len_mask = 4'h7;
      3'h4:    len_mask = 4'hF;
      // reserved codes fall back to two beats
      default: len_mask = 4'h1;
    endcase
  end

  assign burst_len_o = {1'b0, len_mask} + 5'h01;
  assign interleave_o = std_cfg[`LMC_BT_BIT]; // R7
  assign read_latency_setting_o =
    (std_cfg[`LMC_CL_LSB +: 3] == 3'h2) ? 2'h2 : 2'h3; // R8
  // reserved upper bits flag unknown operation
  assign reserved_mode_o = |std_cfg[11:`LMC_OPMODE_LSB]; // R10 R11

  // refresh coverage; access never gated by it
  always_comb begin
    unique case (ext_cfg[`LMC_PARTIAL_REFRESH_SELECT_LSB +: 3]) // R15 R16 R17
      3'h1: begin
        kept_banks              = 3'h2;
        refresh_row_zero_bits_o = 2'h0;
      end
      3'h2: begin
        kept_banks              = 3'h1;
        refresh_row_zero_bits_o = 2'h0;
      end
      3'h5: begin
        kept_banks              = 3'h1;
        refresh_row_zero_bits_o = 2'h1;
      end
      3'h6: begin
        kept_banks              = 3'h1;
        refresh_row_zero_bits_o = 2'h2;
      end
      default: begin
        kept_banks              = 3'h4;
        refresh_row_zero_bits_o = 2'h0;
      end
    endcase
  end

  // bank b kept when it lies below the kept count
  for (genvar b = 0; b < 4; b++) begin : g_bank
    assign refresh_bank_mask_o[b] = 3'(b) < kept_banks; // R15
  end

  // temperature bits stored but never read: R14
  // impedance in ohms per drive code
  always_comb begin
    unique case (ext_cfg[`LMC_DS_LSB +: 2]) // R18
      2'h1:    drive_ohms_o = 6'd37;
      2'h2:    drive_ohms_o = 6'd55;
      default: drive_ohms_o = 6'd25;
    endcase
  end

  // burst start; upper column bits only pick the block
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      start <= 4'h0;
    end else if (bus.cmd == LMC_CMD_READ || bus.cmd == LMC_CMD_WRITE) begin
      start <= bus.addr[3:0] & len_mask; // R3 R4 R6
    end
  end

  // read latency pipeline then burst beats
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      lat_run <= 1'b0;
      lat_cnt <= 3'h0;
    end else if (bus.cmd == LMC_CMD_READ || bus.cmd == LMC_CMD_WRITE) begin
      lat_run <= 1'b1;
      lat_cnt <= (bus.cmd == LMC_CMD_READ) ?
                 {1'b0, read_latency_setting_o} - 3'h1 : 3'h0; // R8 R9
    end else if (lat_run && lat_cnt == 3'h0) begin
      lat_run <= 1'b0;
    end else if (lat_run) begin
      lat_cnt <= lat_cnt - 3'h1;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      active <= 1'b0;
      beat   <= 4'h0;
    end else if (lat_run && lat_cnt == 3'h0) begin
      active <= 1'b1;
      beat   <= 4'h0;
    end else if (active && beat == len_mask) begin
      active <= 1'b0;
    end else if (active) begin
      beat <= beat + 4'h1;
    end
  end

  // offsets wrap inside the aligned block
  always_comb begin
    if (interleave_o) begin
      next_offset = (start ^ beat) & len_mask; // R21 R7
    end else begin
      next_offset = (start + beat) & len_mask; // R21 R2
    end
  end

  // beat outputs; offset parks at zero between bursts
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      bus.col_offset <= 4'h0;
    end else begin
      bus.col_offset <= active ? next_offset : 4'h0;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      bus.data_valid <= 1'b0;
    end else begin
      bus.data_valid <= active;
    end
  end

  // last beat flagged alongside its data
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      bus.data_last <= 1'b0;
    end else begin
      bus.data_last <= active && beat == len_mask;
    end
  end
endmodule

/* rtl/lmc_ctrl.sv */
`timescale 1ns/1ps
`include "lmc_defines.svh"
module lmc_ctrl
  import lmc_pkg::*;
(
  // clock and reset
  input  wire logic        mclk_i,
  input  wire logic        rst_b_i,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // link
  lmc_if.ctrl              bus
);
  logic [31:0] ctrl_reg;
  logic [11:0] addr_reg;
  logic        wr_ph;
  logic        rd_ph;
  logic [31:0] ph_addr;
  logic        busy;
  logic [1:0]  wait_cnt;
  logic [4:0]  beats;
  logic        go;
  logic        pend;
  logic [3:0]  last_off;

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wr_ph   <= 1'b0;
      rd_ph   <= 1'b0;
      ph_addr <= 32'h0000_0000;
    end else if (hready) begin
      wr_ph   <= hsel && htrans[1] && hwrite;
      rd_ph   <= hsel && htrans[1] && !hwrite;
      ph_addr <= haddr;
    end
  end

  // ctrl: [2:0] command, [4:3] bank select, write starts it
  assign go = wr_ph && ph_addr == `LMC_OFS_CTRL && !busy;

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ctrl_reg <= 32'h0000_0000;
      addr_reg <= 12'h000;
    end else if (wr_ph) begin
      if (ph_addr == `LMC_OFS_CTRL) begin
        ctrl_reg <= {27'h0, hwdata[4:0]};
      end
      if (ph_addr == `LMC_OFS_ADDR) begin
        addr_reg <= hwdata[11:0];
      end
    end
  end

  // issue one command, then hold off for load wait or data
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      bus.cmd      <= LMC_CMD_NOP;
      bus.bank_sel <= 2'h0;
      bus.addr     <= 12'h000;
      busy         <= 1'b0;
      wait_cnt     <= 2'h0;
    end else if (go) begin
      bus.cmd      <= hwdata[2:0];
      bus.bank_sel <= hwdata[4:3];
      bus.addr     <= (hwdata[2:0] == LMC_CMD_LOAD && hwdata[4:3] == 2'h0) ?
                      {5'h00, addr_reg[6:0]} : addr_reg; // R10 R11
      busy         <= 1'b1;
      wait_cnt     <= 2'(`LMC_MRD_CYC); // R20
    end else begin
      bus.cmd <= LMC_CMD_NOP;
      if (wait_cnt != 2'h0) begin
        wait_cnt <= wait_cnt - 2'h1;
      end else if (busy && (bus.cmd == LMC_CMD_NOP) && !pend) begin
        busy <= 1'b0;
      end
    end
  end

  // a read or write stays pending until its last beat
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pend <= 1'b0;
    end else if (go) begin
      pend <= hwdata[2:0] == LMC_CMD_READ ||
              hwdata[2:0] == LMC_CMD_WRITE; // R20
    end else if (bus.data_last) begin
      pend <= 1'b0;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      beats    <= 5'h00;
      last_off <= 4'h0;
    end else if (go) begin
      beats    <= 5'h00;
      last_off <= 4'h0;
    end else if (bus.data_valid) begin
      beats    <= beats + 5'h01;
      last_off <= bus.col_offset;
    end
  end

  always_comb begin
    hrdata = 32'h0000_0000;
    if (rd_ph) begin
      unique case (ph_addr)
        `LMC_OFS_CTRL:   hrdata = ctrl_reg;
        `LMC_OFS_ADDR:   hrdata = {20'h0, addr_reg};
        `LMC_OFS_STATUS: hrdata = {22'h0, last_off, beats, busy};
        default:         hrdata = 32'h0000_0000;
      endcase
    end
  end
endmodule

/* tb/lmc_props.sv */
`timescale 1ns/1ps
`include "lmc_defines.svh"
module lmc_props
  import lmc_pkg::*;
(
  // clock and reset
  input wire logic        mclk_i,
  input wire logic        rst_b_i,
  // link
  input wire logic [2:0]  cmd,
  input wire logic [1:0]  bank_sel,
  input wire logic [11:0] addr,
  input wire logic [3:0]  col_offset,
  input wire logic        data_valid,
  input wire logic        data_last
);
  logic [11:0] std;
  logic [3:0]  st;
  logic [3:0]  k;
  logic [3:0]  m;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_b_i);
  assign m = 4'((5'h1 << std[2:0]) - 5'h1);
  // mirror of the standard settings
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) std <= `LMC_STD_RESET;
    else if (cmd == LMC_CMD_DPD) std <= `LMC_STD_RESET;
    else if (cmd == LMC_CMD_LOAD && bank_sel == 2'h0) std <= addr;
  end
  // burst start and beat count
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st <= 4'h0;
      k  <= 4'h0;
    end else if (cmd == LMC_CMD_READ || cmd == LMC_CMD_WRITE) begin
      st <= addr[3:0];
      k  <= 4'h0;
    end else if (data_valid) begin
      k <= k + 4'h1;
    end
  end
  property p_lat3;
    cmd == LMC_CMD_READ && std[6:4] == 3'h3
      |=> !data_valid[*4] ##1 data_valid;
  endproperty
  property p_lat2;
    cmd == LMC_CMD_READ && std[6:4] == 3'h2
      |=> !data_valid[*3] ##1 data_valid;
  endproperty
  property p_wr;
    cmd == LMC_CMD_WRITE |=> !data_valid[*2] ##1 data_valid;
  endproperty
  property p_blk; data_valid |-> (col_offset & ~m) == 4'h0; endproperty
  property p_ord;
    data_valid |-> col_offset == ((std[3] ? st ^ k : st + k) & m);
  endproperty
  property p_full; data_valid && k == m |-> data_last; endproperty
  property p_run; data_valid && !data_last |=> data_valid; endproperty
  property p_last; data_last |-> data_valid && k == m; endproperty
  a_lat3: assert property (p_lat3) else $error("latency 3 off");
  a_lat2: assert property (p_lat2) else $error("latency 2 off");
  a_wr: assert property (p_wr) else $error("write beats late");
  a_blk: assert property (p_blk) else $error("left block");
  a_ord: assert property (p_ord) else $error("bad column order");
  a_full: assert property (p_full) else $error("burst too long");
  a_run: assert property (p_run) else $error("burst broken");
  a_last: assert property (p_last) else $error("burst too short");
  c_lat2: cover property (cmd == LMC_CMD_READ && std[6:4] == 3'h2);
  c_il16: cover property (data_last && std[3] && std[2:0] == 3'h4);
  c_ext: cover property (cmd == LMC_CMD_LOAD && bank_sel == 2'h2);
endmodule

/* tb/lmc_tb_top.sv */
`timescale 1ns/1ps
`include "lmc_defines.svh"
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin n_errors++; \
  $display("mismatch t=%0t got=%0h exp=%0h", $time, g, e); end end
module lmc_tb_top;
  import lmc_pkg::*;
  logic        mclk_i, rst_b_i, hsel, hwrite, hreadyout, hresp;
  logic        ilv, rsv;
  logic [1:0]  htrans, lat, rz;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [4:0]  blen;
  logic [3:0]  bmask;
  logic [5:0]  ohms;
  logic [2:0]  pr[5] = '{3'h0, 3'h1, 3'h2, 3'h5, 3'h6};
  logic [5:0]  ex[5] = '{6'h3C, 6'h0C, 6'h04, 6'h05, 6'h06};
  logic [5:0]  dr[3] = '{6'h19, 6'h25, 6'h37};
  int          n_errors = 0, checks = 0, cyc = 0;
  lmc_if bus_if();
  lmc_ctrl lmc_ctrl_i(.mclk_i, .rst_b_i, .hsel, .haddr, .htrans, .hwrite,
    .hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
    .bus(bus_if));
  lmc_device lmc_device_i(.mclk_i, .rst_b_i, .bus(bus_if),
    .burst_len_o(blen), .interleave_o(ilv), .read_latency_setting_o(lat),
    .reserved_mode_o(rsv), .refresh_bank_mask_o(bmask),
    .refresh_row_zero_bits_o(rz), .drive_ohms_o(ohms));
  lmc_props lmc_props_i(.mclk_i, .rst_b_i, .cmd(bus_if.cmd),
    .bank_sel(bus_if.bank_sel), .addr(bus_if.addr),
    .col_offset(bus_if.col_offset), .data_valid(bus_if.data_valid),
    .data_last(bus_if.data_last));
  initial begin
    mclk_i = 1'b0;
    forever #2.5 mclk_i = ~mclk_i;
  end
  always @(posedge mclk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      finish_test();
    end
  end
  task automatic finish_test();
    $display("checks=%0d n_errors=%0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic ahb(input logic w, input logic [31:0] a, d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(posedge mclk_i); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge mclk_i); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  // {bank, command} then wait while busy
  task automatic issue(input logic [4:0] c, input logic [11:0] a);
    ahb(1'b1, `LMC_OFS_ADDR, {20'h0, a});
    ahb(1'b1, `LMC_OFS_CTRL, {27'h0, c});
    do ahb(1'b0, `LMC_OFS_STATUS, 32'h0); while (rd[0] !== 1'b0);
  endtask
  initial begin
    rst_b_i = 1'b0;
    hsel = 1'b0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    haddr = 32'h0;
    hwdata = 32'h0;
    repeat (4) @(posedge mclk_i);
    rst_b_i <= 1'b1;
    @(posedge mclk_i);
    `CHK({blen, ilv, lat, rsv, hreadyout, hresp},
         {5'h04, 1'b0, 2'h3, 1'b0, 2'h2})
    `CHK({bmask, rz, ohms}, {4'hF, 2'h0, 6'h19})
    $display("reset test done");
    for (int t = 0; t < 8; t++) begin
      logic [2:0]  cd, lt;
      logic        ty;
      logic [3:0]  m, s, e;
      logic [11:0] a;
      cd = 3'(t % 4 + 1);
      lt = 3'(2 + t % 2);
      ty = t[2];
      m = 4'((5'h1 << cd) - 5'h1);
      a = {8'h5A, 4'(t * 7 + 3)};
      s = a[3:0] & m;
      e = ty ? (s ^ m) : ((s + m) & m);
      issue({2'h0, LMC_CMD_LOAD}, {5'h0, lt, ty, cd});
      `CHK({blen, ilv, lat}, {5'(1 << cd), ty, lt[1:0]})
      issue({2'h0, LMC_CMD_READ}, a);
      `CHK(rd[9:6], e)
      `CHK(rd[5:1], 5'(1 << cd))
      issue({2'h0, LMC_CMD_WRITE}, a);
      `CHK(rd[9:6], e)
      `CHK(rd[5:1], 5'(1 << cd))
    end
    $display("burst test done");
    for (int i = 0; i < 5; i++) begin
      issue({2'h2, LMC_CMD_LOAD}, {5'h0, 2'(i % 3), 2'h3, pr[i]});
      `CHK({bmask, rz}, ex[i])
      `CHK(ohms, dr[i % 3])
    end
    issue({2'h1, LMC_CMD_LOAD}, 12'h000);
    `CHK({bmask, rz, ohms, blen}, {6'h06, 6'h25, 5'h10})
    $display("extended test done");
    issue({2'h0, LMC_CMD_LOAD}, 12'h0B2);
    `CHK({rsv, blen, ilv, lat}, {1'b0, 5'h04, 1'b0, 2'h3})
    issue({2'h0, LMC_CMD_DPD}, 12'h000);
    `CHK({blen, ilv, lat, rsv, bmask, rz, ohms},
         {5'h04, 1'b0, 2'h3, 1'b0, 4'hF, 2'h0, 6'h19})
    $display("deep sleep test done");
    finish_test();
  end
endmodule
